//--- shift_move_defines.svh
`ifndef SHIFT_MOVE_DEFINES_SVH
`define SHIFT_MOVE_DEFINES_SVH

`define OPR_ADDR_W      7
`define PTR_W           16
`define OFFS_W          6
`define DATA_W          8
`define BANK_W          6
`define DMEM_ADDR_W     13
`define WIN0_ADDR       7'h00
`define WIN1_ADDR       7'h01
`define ACC_RESET       8'h00
`define PTR_RESET       16'h0000
`define MM_PRE_INC      2'h0
`define MM_PRE_DEC      2'h1
`define MM_POST_INC     2'h2
`define MM_POST_DEC     2'h3

`endif

//--- shift_move_pkg.sv
package shift_move_pkg;

	typedef enum logic [2:0] {
		OP_NONE  = 3'h1,
		OP_SHIFT = 3'h2,
		OP_MOVE  = 3'h4
	} op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_READ  = 3'h2,
		ST_WRITE = 3'h4
	} state_t;

endpackage : shift_move_pkg

//--- ptr_step.sv
`timescale 1ns/1ps
`include "shift_move_defines.svh"

// Effective address and next pointer value for one indirect load
module ptr_step (
	// Pointer and mode
	input  wire logic [15:0] PTR,
	input  wire logic [1:0]  MODE,
	input  wire logic        REL,
	input  wire logic [5:0]  OFFSET,
	// Results
	output logic      [15:0] EFF_ADDR,
	output logic      [15:0] NEXT_PTR
);

	logic [15:0] inc;
	logic [15:0] dec;
	logic [15:0] offs_ext;

	// 16-bit adders wrap naturally at both ends
	assign inc      = PTR + 16'h0001;
	assign dec      = PTR - 16'h0001;
	assign offs_ext = {{10{OFFSET[5]}}, OFFSET};

	always_comb begin
		if (REL) begin
			EFF_ADDR = PTR + offs_ext;
			NEXT_PTR = PTR;
		end else begin
			unique case (MODE)
				`MM_PRE_INC: begin
					EFF_ADDR = inc;
					NEXT_PTR = inc;
				end
				`MM_PRE_DEC: begin
					EFF_ADDR = dec;
					NEXT_PTR = dec;
				end
				`MM_POST_INC: begin
					EFF_ADDR = PTR;
					NEXT_PTR = inc;
				end
				`MM_POST_DEC: begin
					EFF_ADDR = PTR;
					NEXT_PTR = dec;
				end
			endcase
		end
	end

endmodule : ptr_step

//--- shift_move_indirect_exec.sv
`timescale 1ns/1ps
`include "shift_move_defines.svh"

// Summary of operation
// - Right shift moves bits 7:1 to 6:0, bit 0 to carry, zero to bit 7.
// - Target 0 writes accumulator; target 1 writes back to operand register.
// - File move copies operand register unchanged to chosen target.
// - File move updates zero flag even when writing back in place.
// - Indirect load reads through pointer 0 or 1 into accumulator.
// - Effective address is pointer+1, pointer-1, pointer itself for post modes, or pointer plus signed offset.
// - Update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Pointer ends +1 for increments, -1 for decrements, unchanged for offset.
// - Relative offset is signed, -32 to 31, added to pointer.
// - Window addresses have no storage; they redirect through their pointer.
// - Pointers are 16 bits and wrap at both ends.
// - Window access uses the current pointer value; the pointer is not stepped.
// - Pointer steps leave all status bits untouched.
module shift_move_indirect_exec (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESET_N,
	// Instruction issue
	input  wire logic        SHIFT_REQ,
	input  wire logic        MOVE_REQ,
	input  wire logic        LOAD_REQ,
	input  wire logic [6:0]  OPERAND_ADDR,
	input  wire logic        TARGET_CHOICE,
	input  wire logic [5:0]  BANK_SELECT,
	input  wire logic        PTR_INDEX,
	input  wire logic [1:0]  POINTER_UPDATE_CODE,
	input  wire logic        REL_FORM,
	input  wire logic [5:0]  SIGNED_OFFSET,
	output logic             BUSY,
	output logic             DONE,
	// Pointer load from the core
	input  wire logic        PTR_WR,
	input  wire logic        PTR_WR_SEL,
	input  wire logic [15:0] PTR_WR_DATA,
	// Data memory
	output logic             MEM_RD,
	output logic             MEM_WR,
	output logic      [15:0] MEM_ADDR,
	output logic      [7:0]  MEM_WDATA,
	input  wire logic [7:0]  MEM_RDATA,
	// Architectural state
	output logic      [7:0]  ACC,
	output logic      [15:0] PTR0,
	output logic      [15:0] PTR1,
	output logic             ZERO_FLAG,
	output logic             CARRY_FLAG
);

	typedef struct packed {
		shift_move_pkg::state_t st;
		shift_move_pkg::op_t    op;
		logic                   tgt;
		logic                   load;
		logic [15:0]            addr;
		logic [15:0]            ptr0;
		logic [15:0]            ptr1;
		logic [7:0]             acc;
		logic                   zero;
		logic                   carry;
		logic                   rd;
		logic                   wr;
		logic [7:0]             wdata;
		logic                   done;
	} state_s_t;

	state_s_t s_q;
	state_s_t s_d;

	logic [15:0] sel_ptr;
	logic [15:0] eff_addr;
	logic [15:0] next_ptr;
	logic [15:0] direct_addr;
	logic [7:0]  result;
	logic        window_hit;
	logic        window_sel;
	logic [15:0] window_ptr;

	// Selected pointer for the load
	assign sel_ptr = PTR_INDEX ? s_q.ptr1 : s_q.ptr0;

	ptr_step u_ptr_step (
		.PTR      (sel_ptr),
		.MODE     (POINTER_UPDATE_CODE),
		.REL      (REL_FORM),
		.OFFSET   (SIGNED_OFFSET),
		.EFF_ADDR (eff_addr),
		.NEXT_PTR (next_ptr)
	);

	// Window addresses redirect through their pointer
	assign window_hit = (OPERAND_ADDR == `WIN0_ADDR) ||
		(OPERAND_ADDR == `WIN1_ADDR);
	assign window_sel = (OPERAND_ADDR == `WIN1_ADDR);
	assign window_ptr = window_sel ? s_q.ptr1 : s_q.ptr0;
	// Bank plus 7-bit offset
	assign direct_addr = {3'h0, BANK_SELECT, OPERAND_ADDR};

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		s_d.rd   = 1'b0;
		s_d.wr   = 1'b0;
		result   = 8'h00;
		unique case (s_q.st)
			shift_move_pkg::ST_IDLE: begin
				// Pointer writes from the core are ignored mid-instruction
				if (PTR_WR) begin
					if (PTR_WR_SEL)
						s_d.ptr1 = PTR_WR_DATA;
					else
						s_d.ptr0 = PTR_WR_DATA;
				end
				if (LOAD_REQ) begin
					s_d.load = 1'b1;
					s_d.op   = shift_move_pkg::OP_NONE;
					s_d.addr = eff_addr;
					// No flag is touched by the step
					if (PTR_INDEX)
						s_d.ptr1 = next_ptr;
					else
						s_d.ptr0 = next_ptr;
					s_d.rd = 1'b1;
					s_d.st = shift_move_pkg::ST_READ;
				end else if (SHIFT_REQ || MOVE_REQ) begin
					s_d.load = 1'b0;
					s_d.op   = SHIFT_REQ ? shift_move_pkg::OP_SHIFT :
						shift_move_pkg::OP_MOVE;
					s_d.tgt  = TARGET_CHOICE;
					s_d.addr = window_hit ? window_ptr : direct_addr;
					s_d.rd   = 1'b1;
					s_d.st   = shift_move_pkg::ST_READ;
				end
			end
			shift_move_pkg::ST_READ: begin
				if (s_q.load) begin
					s_d.acc  = MEM_RDATA;
					s_d.zero = (MEM_RDATA == 8'h00);
					s_d.done = 1'b1;
					s_d.st   = shift_move_pkg::ST_IDLE;
				end else begin
					if (s_q.op == shift_move_pkg::OP_SHIFT) begin
						result      = {1'b0, MEM_RDATA[7:1]};
						s_d.carry   = MEM_RDATA[0];
					end else begin
						result = MEM_RDATA;
					end
					s_d.zero = (result == 8'h00);
					if (s_q.tgt) begin
						s_d.wdata = result;
						s_d.wr    = 1'b1;
						s_d.st    = shift_move_pkg::ST_WRITE;
					end else begin
						s_d.acc  = result;
						s_d.done = 1'b1;
						s_d.st   = shift_move_pkg::ST_IDLE;
					end
				end
			end
			shift_move_pkg::ST_WRITE: begin
				s_d.done = 1'b1;
				s_d.st   = shift_move_pkg::ST_IDLE;
			end
			default: begin
				s_d.st = shift_move_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			s_q.st    <= shift_move_pkg::ST_IDLE;
			s_q.op    <= shift_move_pkg::OP_NONE;
			s_q.tgt   <= 1'b0;
			s_q.load  <= 1'b0;
			s_q.addr  <= 16'h0000;
			s_q.ptr0  <= `PTR_RESET;
			s_q.ptr1  <= `PTR_RESET;
			s_q.acc   <= `ACC_RESET;
			s_q.zero  <= 1'b0;
			s_q.carry <= 1'b0;
			s_q.rd    <= 1'b0;
			s_q.wr    <= 1'b0;
			s_q.wdata <= 8'h00;
			s_q.done  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Read data is taken in the same cycle the address is driven; memory is combinational
	assign BUSY       = (s_q.st != shift_move_pkg::ST_IDLE);
	assign DONE       = s_q.done;
	assign MEM_RD     = s_q.rd;
	assign MEM_WR     = s_q.wr;
	assign MEM_ADDR   = s_q.addr;
	assign MEM_WDATA  = s_q.wdata;
	assign ACC        = s_q.acc;
	assign PTR0       = s_q.ptr0;
	assign PTR1       = s_q.ptr1;
	assign ZERO_FLAG  = s_q.zero;
	assign CARRY_FLAG = s_q.carry;

endmodule : shift_move_indirect_exec

//--- shift_move_indirect_exec_assertions.sv
`timescale 1ns/1ps
module sm_exec_checker (
	// Clock, reset and issue
	input wire logic        SYS_CLK, RESET_N, SHIFT_REQ, MOVE_REQ,
	input wire logic        LOAD_REQ, TARGET_CHOICE, PTR_INDEX, REL_FORM,
	input wire logic [6:0]  OPERAND_ADDR,
	input wire logic [5:0]  BANK_SELECT, SIGNED_OFFSET,
	input wire logic [1:0]  POINTER_UPDATE_CODE,
	// Results
	input wire logic        BUSY, DONE, MEM_WR, ZERO_FLAG, CARRY_FLAG,
	input wire logic [7:0]  MEM_WDATA, MEM_RDATA, ACC,
	input wire logic [15:0] MEM_ADDR, PTR0, PTR1
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	wire        ld = LOAD_REQ && !BUSY;
	wire        sm = (SHIFT_REQ || MOVE_REQ) && !BUSY && !LOAD_REQ;
	wire        l0 = ld && !REL_FORM && !PTR_INDEX;
	wire [15:0] p  = PTR_INDEX ? PTR1 : PTR0;
	a_pre_step: assert property (l0 && !POINTER_UPDATE_CODE[1] |=>
		MEM_ADDR == PTR0 && PTR0 == $past(PTR0)
		+ ($past(POINTER_UPDATE_CODE[0]) ? 16'hFFFF : 16'h0001))
		else $error("pre step address wrong");
	a_post_step: assert property (l0 && POINTER_UPDATE_CODE[1] |=>
		MEM_ADDR == $past(PTR0) && PTR0 == $past(PTR0)
		+ ($past(POINTER_UPDATE_CODE[0]) ? 16'hFFFF : 16'h0001))
		else $error("post step wrong");
	a_rel_addr: assert property (ld && REL_FORM |=>
		MEM_ADDR == $past(p) + {{10{$past(SIGNED_OFFSET[5])}},
		$past(SIGNED_OFFSET)} && $stable(PTR0) && $stable(PTR1))
		else $error("relative address wrong");
	a_load_flags: assert property (ld |-> ##2 DONE &&
		ACC == $past(MEM_RDATA) && ZERO_FLAG == (ACC == 8'h00)
		&& CARRY_FLAG == $past(CARRY_FLAG, 2))
		else $error("load result wrong");
	a_shift_acc: assert property (sm && SHIFT_REQ && !TARGET_CHOICE
		|-> ##2 ACC == ($past(MEM_RDATA) >> 1)
		&& CARRY_FLAG == $past(MEM_RDATA[0]))
		else $error("shift result wrong");
	a_move_wb: assert property (sm && !SHIFT_REQ && TARGET_CHOICE
		|-> ##2 MEM_WR && MEM_WDATA == $past(MEM_RDATA)
		&& ZERO_FLAG == (MEM_WDATA == 8'h00) ##1 DONE)
		else $error("move write back wrong");
	a_direct_addr: assert property (sm && OPERAND_ADDR > 7'h01 |=>
		MEM_ADDR == {3'h0, $past(BANK_SELECT), $past(OPERAND_ADDR)})
		else $error("direct address wrong");
	a_window_addr: assert property (sm && OPERAND_ADDR < 7'h02 |=>
		MEM_ADDR == ($past(OPERAND_ADDR[0]) ? PTR1 : PTR0))
		else $error("window address wrong");
	cover property (l0);
	cover property (ld && REL_FORM);
	cover property (sm && TARGET_CHOICE);
endmodule : sm_exec_checker

bind shift_move_indirect_exec sm_exec_checker u_chk (.*);

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        SYS_CLK = 1'b0, RESET_N = 1'b0, SHIFT_REQ = 1'b0;
	logic        MOVE_REQ = 1'b0, LOAD_REQ = 1'b0, TARGET_CHOICE = 1'b0;
	logic        PTR_INDEX = 1'b0, REL_FORM = 1'b0, PTR_WR = 1'b0;
	logic        PTR_WR_SEL = 1'b0, BUSY, DONE, MEM_RD, MEM_WR, z, c;
	logic        ZERO_FLAG, CARRY_FLAG;
	logic [6:0]  OPERAND_ADDR = 7'h00;
	logic [5:0]  BANK_SELECT = 6'h00, SIGNED_OFFSET = 6'h00;
	logic [1:0]  POINTER_UPDATE_CODE = 2'h0;
	logic [15:0] PTR_WR_DATA = 16'h0000, MEM_ADDR, PTR0, PTR1, p0, p1;
	logic [7:0]  MEM_RDATA = 8'h00, MEM_WDATA, ACC, lf = 8'h0B;
	logic [58:0] x;
	logic [58:0] q[$];
	int          fails = 0;
	int          check_count = 0;
	int          rd_n = 0;
	shift_move_indirect_exec DUT (.*);
	always #25 SYS_CLK = ~SYS_CLK;
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nx
	task automatic ldp(input logic s, input logic [15:0] v);
		@(posedge SYS_CLK);
		PTR_WR <= 1'b1;
		PTR_WR_SEL <= s;
		PTR_WR_DATA <= v;
		@(posedge SYS_CLK);
		PTR_WR <= 1'b0;
		if (s) p1 = v;
		else p0 = v;
	endtask : ldp
	// Model first, then issue; requests stay up for exactly the take edge
	task automatic op(input int k, input logic t, input logic [6:0] a,
		input logic [1:0] m, input logic r, input logic [5:0] o,
		input logic [7:0] d);
		logic [15:0] b, e;
		logic [7:0] v;
		int n;
		b = a[0] ? p1 : p0;
		e = r ? b + {{10{o[5]}}, o} : m == 2'h0 ? b + 16'h1
			: m == 2'h1 ? b - 16'h1 : b;
		if (k < 2) e = a == 7'h0 ? p0 : a == 7'h1 ? p1 : {3'h0, lf[5:0], a};
		else if (!r) begin
			b = m[0] ? b - 16'h1 : b + 16'h1;
			if (a[0]) p1 = b;
			else p0 = b;
		end
		v = k == 0 ? d >> 1 : d;
		if (k == 0) c = d[0];
		z = v == 8'h00;
		q.push_back({k < 2 && t, v, z, c, p0, p1, e});
		@(posedge SYS_CLK);
		{SHIFT_REQ, MOVE_REQ, LOAD_REQ} <= 3'h4 >> k;
		TARGET_CHOICE <= t;
		OPERAND_ADDR <= a;
		BANK_SELECT <= lf[5:0];
		PTR_INDEX <= a[0];
		POINTER_UPDATE_CODE <= m;
		REL_FORM <= r;
		SIGNED_OFFSET <= o;
		MEM_RDATA <= d;
		@(posedge SYS_CLK);
		{SHIFT_REQ, MOVE_REQ, LOAD_REQ} <= 3'h0;
		n = 0;
		do @(negedge SYS_CLK); while (DONE !== 1'b1 && ++n < 9);
		lf = nx(lf);
	endtask : op
	always @(negedge SYS_CLK) if (DONE === 1'b1) begin
		x = q.size() ? q.pop_front() : '1;
		check_count++;
		if ({x[58] ? MEM_WDATA : ACC, ZERO_FLAG, CARRY_FLAG, PTR0, PTR1,
			MEM_ADDR} !== x[57:0]) begin
			fails++;
			$display("ERROR %0t result mismatch, expected %h", $time, x);
		end
	end
	// One read strobe per instruction, and idle again once done
	always @(negedge SYS_CLK) begin
		if (MEM_RD === 1'b1) rd_n++;
		if (DONE === 1'b1) begin
			check_count++;
			if (rd_n != 1 || BUSY !== 1'b0) begin
				fails++;
				$display("ERROR %0t read strobe or busy wrong", $time);
			end
			rd_n = 0;
		end
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	initial begin
		repeat (3000) @(posedge SYS_CLK);
		fails++;
		summarize();
	end
	initial begin
		{p0, p1, z, c} = '0;
		repeat (12) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		for (int i = 0; i < 16; i++)
			op(i[0], i[1], lf[7:1], 2'h0, 1'b0, 6'h00,
				i[2] ? {7'h0, i[3]} : lf);
		$display("shift and move test done");
		ldp(1'b0, 16'hFFFF);
		ldp(1'b1, 16'h0000);
		for (int i = 0; i < 8; i++)
			op(2, 1'b0, {6'h0, i[0]}, i[2:1] ^ {1'b0, i[0]}, 1'b0, 6'h00,
				lf);
		$display("pointer step test done");
		for (int i = 0; i < 4; i++)
			op(2, 1'b0, {6'h0, i[0]}, i[1:0], 1'b1,
				i[1] ? lf[5:0] : i[0] ? 6'h1F : 6'h20, 8'h00);
		$display("relative offset test done");
		summarize();
	end
endmodule : tb_top
